/* File: hw/vird_pkg.sv */
// shared constants and carrier types for the interrupt and reset dispatch block
package vird_pkg;
	localparam int NSW = 8;
	localparam int NPER = 24;
	localparam int NSRC = NSW + NPER;
	localparam int SRCW = $clog2(NSRC);
	localparam int PRIW = 4;
	localparam int NCAUSE = 4;
	localparam int NCAND = 4;
	localparam int CANDW = 2;
	localparam logic [CANDW-1:0] CAND_LAST = 2'h3;
	// base of the vector table, entries step by four bytes
	localparam logic [31:0] TBL_BASE = 32'h0000_0800;
	localparam logic [15:0] EXT_VEC_OFF = 16'h0040;
	localparam logic [31:0] RST_VEC_OFF = 32'h0000_0004;
	localparam logic [7:0] RESET_CONFIG_HALFWORD_ID = 8'h5a;
	localparam logic [NCAND-1:0][31:0] BOOT_CAND = {
		32'h0003_0000, 32'h0002_0000, 32'h0001_0000, 32'h0000_0000};
	localparam logic [PRIW-1:0] PRI_RST = 4'h0;
	localparam logic [31:0] BOOT_VEC_RST = 32'h0000_0000;

	typedef enum logic [1:0] {
		IRQ_IDLE = 2'b00,
		IRQ_PRESENT = 2'b01,
		IRQ_ACTIVE = 2'b11
	} vird_irq_t;

	typedef enum logic [1:0] {
		BOOT_READ = 2'b00,
		BOOT_WAIT = 2'b01,
		BOOT_DONE = 2'b11,
		BOOT_FAIL = 2'b10
	} vird_boot_t;

	typedef struct packed {
		logic req;
		logic [15:0] vec_off;
		logic fetch_valid;
		logic [31:0] fetch_addr;
		logic [SRCW-1:0] src;
		logic [PRIW-1:0] prio;
	} vird_core_t;

	typedef struct packed {
		logic rd_req;
		logic [31:0] rd_addr;
	} vird_flash_t;

	typedef struct packed {
		logic safe_mode;
		logic clk_sel_rc;
		logic flash_en;
	} vird_mode_t;

	typedef struct packed {
		vird_irq_t irq;
		logic [SRCW-1:0] src;
		logic [PRIW-1:0] prio;
		logic fetch_valid;
		logic [31:0] fetch_addr;
		logic [NSW-1:0] sw_flag;
		vird_boot_t boot;
		logic [CANDW-1:0] cand;
		logic [31:0] boot_vec;
		logic [NCAUSE-1:0] ev_s1;
		logic [NCAUSE-1:0] ev_s2;
		logic [NCAUSE-1:0] ev_prev;
		logic [NCAUSE-1:0] rst_status;
		logic safe_mode;
		logic nmi_req;
		logic sys_reset_req;
	} vird_state_t;
endpackage

/* File: hw/vird_dispatch.sv */
// interrupt priority dispatch, boot vector search and reset event handling
// Functional notes
// [R1] sixteen priority levels; eight software flag sources beside peripheral sources.
// [R2] every request reaches the core through the external input vector offset.
// [R3] hardware vector mode fetches a per-source table entry; software fills table first.
// [R4] software vector mode: one handler reads active source, then uses jump table.
// [R5] table entries step four bytes; software flags 0..7 start at table base.
// [R6] core saves no general registers automatically; handler code does it.
// [R7] machine state register bits enable the core exception classes.
// [R8] a reset event may be handled as a non-maskable interrupt instead.
// [R9] all resets share one vector; cause is read from reset status bits.
// [R10] boot checks candidate flash locations, skipping those without valid config halfword.
// [R11] reset event as interrupt forces fallback mode on rc oscillator, flash on.
// [R12] highest priority pending request is presented; others wait until completion.
module vird_dispatch
	import vird_pkg::*;
(
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [NPER-1:0] periph_req,
	input wire logic [NSW-1:0] sw_flag_set,
	input wire logic [NSW-1:0] sw_flag_clr,
	input wire logic [NSRC-1:0][PRIW-1:0] prio_cfg,
	input wire logic hw_vector_mode,
	input wire logic [31:0] vec_base,
	input wire logic msr_ext_enable,
	input wire logic core_ack,
	input wire logic core_eoi,
	output vird_core_t core,
	output vird_flash_t flash,
	input wire logic flash_rd_valid,
	input wire logic [15:0] flash_rd_data,
	output logic boot_done,
	output logic boot_fail,
	output logic [31:0] reset_vector,
	input wire logic [NCAUSE-1:0] reset_event,
	input wire logic [NCAUSE-1:0] rst_status_clr,
	input wire logic reset_as_nmi,
	input wire logic nmi_ack,
	input wire logic safe_exit,
	input wire logic flash_en_cfg,
	output logic [NCAUSE-1:0] rst_status,
	output logic nmi_req,
	output logic sys_reset_req,
	output vird_mode_t mode
);
	vird_state_t st;
	vird_state_t next_st;
	logic [NSRC-1:0] pend;
	logic [PRIW-1:0] best_prio;
	logic [SRCW-1:0] best_src;
	logic any_elig;
	logic [NCAUSE-1:0] ev_new;

	// [R1] pending set: software flags low
	assign pend = {periph_req, st.sw_flag};

	// [R12] highest priority wins, lowest index on a tie
	always_comb begin
		best_prio = PRI_RST;
		best_src = '0;
		for (int i = 0; i < NSRC; i++) begin
			if (pend[i] && prio_cfg[i] > best_prio) begin
				best_prio = prio_cfg[i];
				best_src = SRCW'(i);
			end
		end
	end
	// priority zero disables a source
	assign any_elig = best_prio != PRI_RST;

	// edges seen only after two flops, first flop read by second only
	assign ev_new = st.ev_s2 & ~st.ev_prev;

	always_comb begin
		next_st = st;
		next_st.sys_reset_req = 1'b0;
		next_st.ev_s1 = reset_event;
		next_st.ev_s2 = st.ev_s1;
		next_st.ev_prev = st.ev_s2;
		// [R1] flags: set wins over clear
		next_st.sw_flag = (st.sw_flag & ~sw_flag_clr) | sw_flag_set;

		// [R10] candidate search for a valid halfword
		case (st.boot)
			BOOT_READ: begin
				next_st.boot = BOOT_WAIT;
			end
			BOOT_WAIT: begin
				if (flash_rd_valid) begin
					if (flash_rd_data[7:0] == RESET_CONFIG_HALFWORD_ID) begin
						next_st.boot = BOOT_DONE;
						next_st.boot_vec = BOOT_CAND[st.cand] + RST_VEC_OFF;
					end else if (st.cand == CAND_LAST) begin
						next_st.boot = BOOT_FAIL;
					end else begin
						next_st.cand = st.cand + 2'h1;
						next_st.boot = BOOT_READ;
					end
				end
			end
			BOOT_DONE: next_st.boot = BOOT_DONE;
			BOOT_FAIL: next_st.boot = BOOT_FAIL;
			default: next_st.boot = BOOT_READ;
		endcase

		case (st.irq)
			IRQ_IDLE: begin
				next_st.fetch_valid = 1'b0;
				// [R7] external class gated by state register bit
				if (any_elig && msr_ext_enable && st.boot == BOOT_DONE) begin
					next_st.irq = IRQ_PRESENT;
					next_st.src = best_src;
					next_st.prio = best_prio;
				end
			end
			IRQ_PRESENT: begin
				// [R6] ack only steers the vector, nothing is stacked
				if (core_ack) begin
					next_st.irq = IRQ_ACTIVE;
					// [R3] per-source entry, [R5] four-byte steps
					next_st.fetch_valid = hw_vector_mode;
					next_st.fetch_addr = vec_base + TBL_BASE + {25'h0, st.src, 2'b00};
				end
			end
			IRQ_ACTIVE: begin
				// [R12] all other requests held off until end, higher ones too
				if (core_eoi) begin
					next_st.irq = IRQ_IDLE;
					next_st.fetch_valid = 1'b0;
				end
			end
			default: next_st.irq = IRQ_IDLE;
		endcase

		// [R9] status bits sticky; new event beats clear
		next_st.rst_status = (st.rst_status & ~rst_status_clr) | ev_new;
		if (nmi_ack) begin
			next_st.nmi_req = 1'b0;
		end
		if (safe_exit) begin
			next_st.safe_mode = 1'b0;
		end
		if (ev_new != '0) begin
			if (reset_as_nmi) begin
				// [R8] event turned into interrupt
				next_st.nmi_req = 1'b1;
				// [R11] fall back to rc clock, flash on
				next_st.safe_mode = 1'b1;
			end else begin
				// [R9] full reset through shared vector
				next_st.sys_reset_req = 1'b1;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			st <= '{irq: IRQ_IDLE, src: '0, prio: PRI_RST, fetch_valid: 1'b0,
				fetch_addr: '0, sw_flag: '0, boot: BOOT_READ, cand: '0,
				boot_vec: BOOT_VEC_RST, ev_s1: '0, ev_s2: '0, ev_prev: '0,
				rst_status: '0, safe_mode: 1'b0, nmi_req: 1'b0,
				sys_reset_req: 1'b0};
		end else begin
			st <= next_st;
		end
	end

	// [R2] single vector offset for every request
	assign core.req = st.irq == IRQ_PRESENT;
	assign core.vec_off = EXT_VEC_OFF;
	assign core.fetch_valid = st.fetch_valid;
	assign core.fetch_addr = st.fetch_addr;
	// [R4] active source readable by the common handler
	assign core.src = st.src;
	assign core.prio = st.prio;
	assign flash.rd_req = st.boot == BOOT_READ;
	assign flash.rd_addr = BOOT_CAND[st.cand];
	assign boot_done = st.boot == BOOT_DONE;
	assign boot_fail = st.boot == BOOT_FAIL;
	// [R9] one vector for all causes
	assign reset_vector = st.boot_vec;
	assign rst_status = st.rst_status;
	assign nmi_req = st.nmi_req;
	assign sys_reset_req = st.sys_reset_req;
	assign mode.safe_mode = st.safe_mode;
	assign mode.clk_sel_rc = st.safe_mode;
	// flash must stay on in fallback whatever the config says
	assign mode.flash_en = st.safe_mode | flash_en_cfg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	chk_vec_offset: assert property (core.req |-> core.vec_off == EXT_VEC_OFF) // [R2]
		else $error("request not on external input vector");
	chk_hw_fetch_addr: assert property ( // [R3]
		core.req && core_ack && hw_vector_mode |=> core.fetch_valid &&
		core.fetch_addr == $past(vec_base) + TBL_BASE + {25'h0, $past(st.src), 2'b00})
		else $error("hardware vector address wrong");
	chk_sw_no_fetch: assert property ( // [R4]
		core.req && core_ack && !hw_vector_mode |=> !core.fetch_valid ##0 core.src == $past(st.src))
		else $error("software mode fetched a vector");
	chk_ext_gate: assert property ( // [R7]
		st.irq == IRQ_IDLE && !msr_ext_enable |=> !core.req)
		else $error("request presented while disabled");
	chk_pick_highest: assert property ( // [R12]
		st.irq == IRQ_IDLE && any_elig && msr_ext_enable && boot_done
		|=> core.req && core.prio == $past(best_prio) && core.src == $past(best_src))
		else $error("wrong source presented");
	chk_hold_off: assert property ( // [R12]
		st.irq == IRQ_ACTIVE && !core_eoi |=> st.irq == IRQ_ACTIVE && $stable(core.src))
		else $error("active request displaced");
	chk_nmi_safe: assert property ( // [R11]
		ev_new != '0 && reset_as_nmi |=> nmi_req && mode.safe_mode && mode.clk_sel_rc
		&& mode.flash_en && !sys_reset_req)
		else $error("nmi event did not force fallback");
	chk_reset_pulse: assert property ( // [R8]
		ev_new != '0 && !reset_as_nmi |=> sys_reset_req ##1 !sys_reset_req)
		else $error("reset request not one pulse");
	chk_status_sticky: assert property ( // [R9]
		ev_new != '0 |=> (rst_status & $past(ev_new)) == $past(ev_new))
		else $error("reset cause lost");
	chk_boot_skip: assert property ( // [R10]
		st.boot == BOOT_WAIT && flash_rd_valid && flash_rd_data[7:0] != RESET_CONFIG_HALFWORD_ID
		&& st.cand != CAND_LAST |=> flash.rd_req && st.cand == $past(st.cand) + 2'h1)
		else $error("invalid candidate not skipped");
	chk_sw_set_wins: assert property ( // [R1]
		sw_flag_set[0] && sw_flag_clr[0] |=> st.sw_flag[0])
		else $error("flag set lost to clear");

	// [R1] clear alone takes effect
	chk_flag_clear: assert property ( // [R1]
		sw_flag_clr[0] && !sw_flag_set[0] |=> !st.sw_flag[0])
		else $error("flag clear ignored");
	// [R1] nothing pending stays quiet
	chk_idle_quiet: assert property ( // [R1]
		st.irq == IRQ_IDLE && pend == '0 |=> !core.req)
		else $error("request presented with nothing pending");
	// [R1] zero priority never presented
	chk_prio_nonzero: assert property (core.req |-> core.prio != PRI_RST) // [R1]
		else $error("masked priority presented");
	// [R2] ack moves request to active
	chk_ack_active: assert property ( // [R2]
		core.req && core_ack |=> !core.req && st.irq == IRQ_ACTIVE)
		else $error("ack did not start handler");
	// [R12] request stands until acked
	chk_req_until_ack: assert property ( // [R12]
		core.req && !core_ack |=> core.req && $stable(core.src) && $stable(core.prio))
		else $error("presented request changed before ack");
	// [R12] end of handler frees the line
	chk_eoi_idle: assert property ( // [R12]
		st.irq == IRQ_ACTIVE && core_eoi |=> !core.req && !core.fetch_valid)
		else $error("end of handler not honoured");
	// [R3] vector stands through the handler
	chk_fetch_stable: assert property ( // [R3]
		st.irq == IRQ_ACTIVE && !core_eoi
		|=> $stable(core.fetch_addr) && $stable(core.fetch_valid))
		else $error("vector changed inside handler");
	// [R10] nothing presented before boot
	chk_boot_first: assert property (!boot_done |-> !core.req) // [R10]
		else $error("request presented before boot");
	// [R10] valid halfword ends search
	chk_boot_found: assert property ( // [R10]
		st.boot == BOOT_WAIT && flash_rd_valid && flash_rd_data[7:0] == RESET_CONFIG_HALFWORD_ID
		|=> boot_done && reset_vector == BOOT_CAND[$past(st.cand)] + RST_VEC_OFF)
		else $error("boot vector not taken from valid candidate");
	// [R10] last invalid candidate fails boot
	chk_boot_fail_last: assert property ( // [R10]
		st.boot == BOOT_WAIT && flash_rd_valid && flash_rd_data[7:0] != RESET_CONFIG_HALFWORD_ID
		&& st.cand == CAND_LAST |=> boot_fail && !boot_done)
		else $error("boot did not fail after last candidate");
	// [R10] read request lasts one cycle
	chk_rd_one_cycle: assert property (flash.rd_req |=> !flash.rd_req) // [R10]
		else $error("read request longer than one cycle");
	// [R10] wait keeps its candidate
	chk_wait_hold: assert property ( // [R10]
		st.boot == BOOT_WAIT && !flash_rd_valid |=> st.boot == BOOT_WAIT && $stable(flash.rd_addr))
		else $error("boot wait left without data");
	// [R10] outcome kept until reset
	chk_boot_sticky: assert property (boot_done |=> boot_done) // [R10]
		else $error("boot outcome lost");
	// [R9] chosen vector never moves
	chk_one_vector: assert property (boot_done |=> $stable(reset_vector)) // [R9]
		else $error("reset vector changed after boot");
	// [R9] clear drops cleared causes
	chk_status_clear: assert property ( // [R9]
		rst_status_clr != '0 && ev_new == '0 |=> (rst_status & $past(rst_status_clr)) == '0)
		else $error("reset cause not cleared");
	// [R9] no event, no reset request
	chk_no_spurious_reset: assert property (ev_new == '0 |=> !sys_reset_req) // [R9]
		else $error("reset request without event");
	// [R8] interrupt held until ack
	chk_nmi_hold: assert property (nmi_req && !nmi_ack |=> nmi_req) // [R8]
		else $error("nmi request dropped early");
	// [R8] ack drops the interrupt
	chk_nmi_clear: assert property (nmi_ack && ev_new == '0 |=> !nmi_req) // [R8]
		else $error("nmi request not cleared");
	// [R11] fallback keeps flash and rc clock
	chk_safe_flash: assert property ( // [R11]
		mode.safe_mode |-> mode.flash_en && mode.clk_sel_rc)
		else $error("fallback mode without flash or rc clock");

	cov_hw_fetch: cover property (core.req && core_ack && hw_vector_mode ##1 core.fetch_valid);
	cov_sw_mode: cover property (core.req && core_ack && !hw_vector_mode);
	cov_nmi: cover property (ev_new != '0 && reset_as_nmi);
	cov_boot_second: cover property (boot_done && st.cand != '0);
	// any request pending while one is active
	cov_prio_wait: cover property (st.irq == IRQ_ACTIVE && pend != '0);
endmodule

/* File: tb/vird_core_model.sv */
// behavioural core side: takes presented requests and runs a handler
module vird_core_model
	import vird_pkg::*;
#(
	parameter int ACK_DLY = 2,
	parameter int EOI_DLY = 3
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire vird_core_t core,
	output logic core_ack,
	output logic core_eoi,
	output logic [SRCW-1:0] got_src,
	output logic [31:0] got_addr,
	output logic got_fv,
	output logic in_handler,
	output logic [7:0] served
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] st;
	int cnt;
	assign in_handler = (st == 2'h2);
	// ack is a one-cycle pulse, so a slow core never double-takes
	always @(negedge sys_clk) begin
		core_ack <= 1'b0;
		core_eoi <= 1'b0;
		if (rst) begin
			st <= 2'h0;
			cnt <= 0;
			served <= 8'h00;
		end else begin
			case (st)
				2'h0: if (core.req === 1'b1) begin
					cnt <= cnt + 1;
					if (cnt == ACK_DLY) begin
						core_ack <= 1'b1;
						st <= 2'h1;
					end
				end
				// handler reads active source and vector
				2'h1: begin
					got_src <= core.src;
					got_addr <= core.fetch_addr;
					got_fv <= core.fetch_valid;
					cnt <= 0;
					st <= 2'h2;
				end
				// handler saves its own registers, hence the delay
				2'h2: begin
					cnt <= cnt + 1;
					if (cnt == EOI_DLY) begin
						core_eoi <= 1'b1;
						served <= served + 8'h01;
						st <= 2'h3;
					end
				end
				// counter restarts so the next request is acked too
				default: begin
					st <= 2'h0;
					cnt <= 0;
				end
			endcase
		end
	end
endmodule

/* File: tb/vird_dispatch_bench.sv */
// self-checking bench for the interrupt and reset dispatch block
module vird_dispatch_bench
	import vird_pkg::*;
();
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 1'b1;
	logic rst = 1'b1;
	logic [NPER-1:0] periph_req = '0;
	logic [NSW-1:0] sw_flag_set = '0;
	logic [NSW-1:0] sw_flag_clr = '0;
	logic [NSRC-1:0][PRIW-1:0] prio_cfg = '0;
	logic hw_vector_mode = 1'b1;
	logic [31:0] vec_base = 32'h0000_1000;
	logic msr_ext_enable = 1'b0;
	logic flash_rd_valid = 1'b0;
	logic [15:0] flash_rd_data = 16'hffff;
	logic [NCAUSE-1:0] reset_event = '0;
	logic [NCAUSE-1:0] rst_status_clr = '0;
	logic reset_as_nmi = 1'b1;
	logic nmi_ack = 1'b0;
	logic safe_exit = 1'b0;
	logic flash_en_cfg = 1'b0;
	logic core_ack;
	logic core_eoi;
	vird_core_t core;
	vird_flash_t flash;
	vird_mode_t mode;
	logic boot_done;
	logic boot_fail;
	logic [31:0] reset_vector;
	logic [NCAUSE-1:0] rst_status;
	logic nmi_req;
	logic sys_reset_req;
	logic [SRCW-1:0] got_src;
	logic [31:0] got_addr;
	logic got_fv;
	logic in_handler;
	logic [7:0] served;
	int mismatches = 0;
	int n_checks = 0;
	int cyc = 0;
	vird_dispatch vird_dispatch_inst (.sys_clk, .rst, .periph_req, .sw_flag_set, .sw_flag_clr,
		.prio_cfg, .hw_vector_mode, .vec_base, .msr_ext_enable, .core_ack, .core_eoi, .core,
		.flash, .flash_rd_valid, .flash_rd_data, .boot_done, .boot_fail, .reset_vector,
		.reset_event, .rst_status_clr, .reset_as_nmi, .nmi_ack, .safe_exit, .flash_en_cfg,
		.rst_status, .nmi_req, .sys_reset_req, .mode);
	vird_core_model vird_core_model_inst (.sys_clk, .rst, .core, .core_ack, .core_eoi,
		.got_src, .got_addr, .got_fv, .in_handler, .served);
	initial forever #25 sys_clk = ~sys_clk;
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
			mismatches++;
		end
	endtask
	task automatic summarize();
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// whole run is about a hundred cycles
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 5000) begin
			mismatches++;
			summarize();
		end
	end
	task automatic cyc_n(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// one halfword answer per candidate, bus released after
	task automatic flash_answer(input logic [31:0] addr, input logic [15:0] data);
		for (int i = 0; i < 50 && flash.rd_req !== 1'b1; i++) cyc_n(1);
		chk(flash.rd_addr, addr);
		cyc_n(2);
		flash_rd_valid = 1'b1;
		flash_rd_data = data;
		cyc_n(1);
		flash_rd_valid = 1'b0;
		flash_rd_data = ~data;
	endtask
	task automatic service(input logic [7:0] n, input logic [4:0] src, input logic [31:0] addr);
		for (int i = 0; i < 100 && served !== n; i++) cyc_n(1);
		chk({27'h0, got_src}, {27'h0, src});
		chk({31'h0, got_fv}, {31'h0, hw_vector_mode});
		if (hw_vector_mode) chk(got_addr, vec_base + TBL_BASE + addr);
	endtask
	task automatic wait_handler();
		for (int i = 0; i < 100 && in_handler !== 1'b1; i++) cyc_n(1);
	endtask
	task automatic test_boot();
		flash_answer(BOOT_CAND[0], 16'h5aa5);
		flash_answer(BOOT_CAND[1], {8'h00, RESET_CONFIG_HALFWORD_ID});
		cyc_n(1);
		chk({boot_done, boot_fail}, 32'h2);
		chk(reset_vector, BOOT_CAND[1] + RST_VEC_OFF);
	endtask
	// enable gate, then peripheral in both vector modes
	task automatic test_periph();
		prio_cfg[8] = 4'h5;
		prio_cfg[31] = 4'h1;
		periph_req[0] = 1'b1;
		cyc_n(20);
		chk({31'h0, core.req}, 32'h0);
		msr_ext_enable = 1'b1;
		wait_handler();
		chk({16'h0, core.vec_off}, {16'h0, EXT_VEC_OFF});
		periph_req[0] = 1'b0;
		service(8'd1, 5'd8, 32'h20);
		hw_vector_mode = 1'b0;
		periph_req[23] = 1'b1;
		wait_handler();
		periph_req[23] = 1'b0;
		service(8'd2, 5'd31, 32'h0);
		hw_vector_mode = 1'b1;
	endtask
	// higher flag first, lower one held
	task automatic test_prio();
		prio_cfg[0] = 4'h3;
		prio_cfg[2] = 4'hf;
		// clear in the same cycle loses to set
		sw_flag_set = 8'h05;
		sw_flag_clr = 8'h01;
		cyc_n(1);
		sw_flag_set = 8'h00;
		sw_flag_clr = 8'h00;
		wait_handler();
		chk({28'h0, core.prio}, 32'hf);
		sw_flag_clr = 8'h04;
		cyc_n(1);
		sw_flag_clr = 8'h00;
		service(8'd3, 5'd2, 32'h8);
		wait_handler();
		sw_flag_clr = 8'h01;
		cyc_n(1);
		sw_flag_clr = 8'h00;
		service(8'd4, 5'd0, 32'h0);
	endtask
	// event as interrupt, then as reset
	task automatic test_events();
		reset_event[0] = 1'b1;
		for (int i = 0; i < 20 && rst_status[0] !== 1'b1; i++) cyc_n(1);
		reset_event[0] = 1'b0;
		chk({nmi_req, sys_reset_req}, 32'h2);
		chk({29'h0, mode}, 32'h7);
		nmi_ack = 1'b1;
		safe_exit = 1'b1;
		cyc_n(1);
		nmi_ack = 1'b0;
		safe_exit = 1'b0;
		reset_as_nmi = 1'b0;
		reset_event[1] = 1'b1;
		for (int i = 0; i < 20 && sys_reset_req !== 1'b1; i++) cyc_n(1);
		reset_event[1] = 1'b0;
		chk({nmi_req, sys_reset_req, mode.safe_mode}, 32'h2);
		chk({28'h0, rst_status}, 32'h3);
		rst_status_clr = 4'h3;
		cyc_n(1);
		rst_status_clr = 4'h0;
		cyc_n(1);
		chk({28'h0, rst_status}, 32'h0);
	endtask
	initial begin
		cyc_n(10);
		rst = 1'b0;
		test_boot();
		test_periph();
		test_prio();
		test_events();
		summarize();
	end
endmodule
